/* hdl/uad_rx.sv */
// Address-detect serial receiver with APB register slave
`timescale 1ns/100ps
`default_nettype none
module uad_rx #(
  parameter int RX_DEPTH = uad_pkg::RX_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             rxIrq
);
  if (RX_DEPTH < 2) begin : g_bad
    $error("uad_rx: RX_DEPTH must be 2 or more");
  end

  logic [7:0] rxStat;
  logic [7:0] txStat;
  logic [7:0] baudCtl;
  logic [7:0] divLo;
  logic [7:0] divHi;
  logic [7:0] irqCtl;
  logic       overrun;
  logic       rxPrev;
  logic [6:0] tickCnt;
  logic [3:0] bitIdx;
  logic [8:0] shift;
  uad_pkg::uad_rxst_t state;

  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic        portEn;
  logic        contRx;
  logic        addrDet;
  logic        nineBit;
  logic        rxOn;
  logic        tick;
  logic [6:0]  full;
  logic [6:0]  half;
  logic        atEnd;
  logic        stopDone;
  logic [7:0]  charData;
  logic        charBit9;
  logic        keep;
  logic        pushValid;
  logic        inReady;
  logic        setOvr;
  logic        outValid;
  logic [9:0]  head;
  logic        pop;
  logic        rdValid;
  logic [31:0] next_prdata;
  logic        next_slverr;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction

  // Oversampling ticks per bit from the two speed selects
  function automatic logic [6:0] bitTicks(input logic wide,
                                          input logic high);
    case ({wide, high})
      2'b00:   bitTicks = uad_pkg::PRE_SLOW;
      2'b11:   bitTicks = uad_pkg::PRE_FAST;
      default: bitTicks = uad_pkg::PRE_MID;
    endcase
  endfunction

  assign setup   = psel & ~penable;
  assign access  = psel & penable & pready;
  assign wr      = access & pwrite;
  assign rd      = access & ~pwrite;
  assign portEn  = rxStat[uad_pkg::RS_PORTEN];
  assign contRx  = rxStat[uad_pkg::RS_CONT];
  assign addrDet = rxStat[uad_pkg::RS_ADDR];
  assign nineBit = rxStat[uad_pkg::RS_NINE];
  assign rxOn    = portEn & contRx & ~txStat[uad_pkg::TS_SYNC]
                   & ~overrun;
  assign full    = bitTicks(baudCtl[uad_pkg::BC_WIDE],
                            txStat[uad_pkg::TS_HIGH]);
  assign half    = full >> 1;
  assign atEnd   = tick & (tickCnt == ((state == uad_pkg::ST_START)
                   ? half - 7'h01 : full - 7'h01));

  uad_baud u_baud (
    .clk     (clk),
    .rst     (rst),
    .enable  (portEn),
    .wide    (baudCtl[uad_pkg::BC_WIDE]),
    .divisor ({divHi, divLo}),
    .tick    (tick)
  );

  // Register writes; status bits are not writable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxStat  <= uad_pkg::REG_RESET;
      txStat  <= uad_pkg::REG_RESET;
      baudCtl <= uad_pkg::REG_RESET;
      divLo   <= uad_pkg::REG_RESET;
      divHi   <= uad_pkg::REG_RESET;
      irqCtl  <= uad_pkg::REG_RESET;
    end else if (wr) begin
      case (paddr)
        uad_pkg::OFS_RXSTAT:
          rxStat <= merge(rxStat, pwdata[7:0], uad_pkg::RS_WMASK);
        uad_pkg::OFS_TXSTAT:
          txStat <= merge(txStat, pwdata[7:0], uad_pkg::TS_WMASK);
        uad_pkg::OFS_BAUDCTL:
          baudCtl <= merge(baudCtl, pwdata[7:0], uad_pkg::BC_WMASK);
        uad_pkg::OFS_DIVLO:
          divLo <= pwdata[7:0];
        uad_pkg::OFS_DIVHI:
          divHi <= pwdata[7:0];
        uad_pkg::OFS_IRQCTL:
          irqCtl <= merge(irqCtl, pwdata[7:0], uad_pkg::IC_WMASK);
        default: ;
      endcase
    end
  end

  // Bit recovery; a single mid-bit sample stands in for majority
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= uad_pkg::ST_IDLE;
      tickCnt <= 7'h00;
      bitIdx  <= 4'h0;
      shift   <= 9'h000;
      rxPrev  <= 1'b1;
    end else begin
      rxPrev <= rxd;
      if (~rxOn) begin
        state   <= uad_pkg::ST_IDLE;
        tickCnt <= 7'h00;
      end else begin
        case (state)
          uad_pkg::ST_IDLE: begin
            tickCnt <= 7'h00;
            if (rxPrev & ~rxd) state <= uad_pkg::ST_START;
          end
          uad_pkg::ST_START: begin
            if (atEnd) begin
              tickCnt <= 7'h00;
              bitIdx  <= 4'h0;
              // Line back high: a glitch, drop it quietly
              state   <= rxd ? uad_pkg::ST_IDLE
                             : uad_pkg::ST_DATA;
            end else if (tick) begin
              tickCnt <= tickCnt + 7'h01;
            end
          end
          uad_pkg::ST_DATA: begin
            if (atEnd) begin
              tickCnt <= 7'h00;
              shift   <= {rxd, shift[8:1]};
              bitIdx  <= bitIdx + 4'h1;
              if (bitIdx == (nineBit ? 4'h8 : 4'h7)) begin
                state <= uad_pkg::ST_STOP;
              end
            end else if (tick) begin
              tickCnt <= tickCnt + 7'h01;
            end
          end
          uad_pkg::ST_STOP: begin
            if (atEnd) begin
              tickCnt <= 7'h00;
              state   <= uad_pkg::ST_IDLE;
            end else if (tick) begin
              tickCnt <= tickCnt + 7'h01;
            end
          end
          default: state <= uad_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Eight-bit characters end one place higher in the shifter
  assign charData  = nineBit ? shift[7:0] : shift[8:1];
  assign charBit9  = nineBit & shift[8];
  assign stopDone  = rxOn & (state == uad_pkg::ST_STOP) & atEnd;
  assign keep      = ~addrDet | charBit9;
  assign pushValid = stopDone & keep;
  assign setOvr    = pushValid & ~inReady;

  // Port disable holds the receiver in reset and empties the buffer
  uad_fifo #(
    .WIDTH (uad_pkg::CHAR_WIDTH),
    .DEPTH (RX_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .flush    (~portEn),
    .inValid  (pushValid),
    .inReady  (inReady),
    .inData   ({~rxd, charBit9, charData}),
    .outValid (outValid),
    .outReady (pop),
    .outData  (head)
  );

  // Pop only what setup latched, so a character landing mid-access stays
  assign pop = rd & (paddr == uad_pkg::OFS_RXDATA) & rdValid;

  // Set beats a receive-disable clear in the same cycle; port disable beats a set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (~portEn) begin
      overrun <= 1'b0;
    end else if (setOvr) begin
      overrun <= 1'b1;
    end else if (~contRx) begin
      overrun <= 1'b0;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      uad_pkg::OFS_RXSTAT:
        next_prdata[7:0] = {rxStat[7:3], outValid & head[9], overrun,
                            outValid & head[8]};
      uad_pkg::OFS_RXDATA:
        next_prdata[7:0] = outValid ? head[7:0] : 8'h00;
      uad_pkg::OFS_TXSTAT: begin
        // No transmitter here, so its shifter always reads empty
        next_prdata[7:0] = txStat;
        next_prdata[uad_pkg::TS_EMPTY] = 1'b1;
      end
      uad_pkg::OFS_BAUDCTL: begin
        next_prdata[7:0] = baudCtl;
        next_prdata[uad_pkg::BC_IDLE] = (state == uad_pkg::ST_IDLE);
      end
      uad_pkg::OFS_DIVLO:
        next_prdata[7:0] = divLo;
      uad_pkg::OFS_DIVHI:
        next_prdata[7:0] = divHi;
      uad_pkg::OFS_IRQCTL: begin
        next_prdata[7:0] = irqCtl;
        next_prdata[uad_pkg::IC_FLAG] = outValid;
      end
      default:
        next_slverr = 1'b1;
    endcase
  end

  // Answer is latched at setup, so each access has one ready cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      rdValid <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & next_slverr;
      if (setup) prdata <= next_prdata;
      if (setup) rdValid <= outValid;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxIrq <= 1'b0;
    end else begin
      rxIrq <= outValid & irqCtl[uad_pkg::IC_RXIE]
               & irqCtl[uad_pkg::IC_GLOBAL]
               & irqCtl[uad_pkg::IC_PERIPH];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_addr_filter: assert property (
    stopDone & addrDet & ~charBit9 & ~pop & ~wr
    |=> $stable(u_fifo.count))
    else $error("ninth-bit-zero character entered buffer");
  chk_ninth_one: assert property (
    pushValid & inReady & addrDet & ~outValid |=> head[8])
    else $error("address mode delivered ninth bit zero");
  chk_ovr_set: assert property (
    pushValid & ~inReady & portEn |=> overrun)
    else $error("third character did not set overrun");
  chk_ovr_stops: assert property (
    overrun |-> state == uad_pkg::ST_IDLE && ~pushValid)
    else $error("reception continued during overrun");
  chk_ovr_clear: assert property (
    overrun & ~contRx & ~setOvr |=> ~overrun)
    else $error("overrun not cleared by receive disable");
  chk_start_abort: assert property (
    rxOn & state == uad_pkg::ST_START & atEnd & rxd
    |=> state == uad_pkg::ST_IDLE)
    else $error("false start was not dropped");
  chk_frame_flag: assert property (
    pushValid & inReady & ~outValid
    |=> outValid && head[9] == ~$past(rxd))
    else $error("framing flag does not follow stop sample");
  chk_irq_gate: assert property (
    rxIrq |-> $past(outValid)
    && ($past(irqCtl) & uad_pkg::IC_WMASK) == uad_pkg::IC_WMASK)
    else $error("interrupt without flag and enable");
  chk_data_pop: assert property (
    pop |-> prdata[7:0] == $past(head[7:0])
    ##1 $changed(u_fifo.rdIdx))
    else $error("data read did not pop the oldest character");

  cov_char_kept: cover property (pushValid & inReady);
  cov_overrun: cover property (setOvr);
  cov_addr_drop: cover property (stopDone & ~keep);
  cov_false_start: cover property (state == uad_pkg::ST_START
                                   & atEnd & rxd);
endmodule // uad_rx
`default_nettype wire

/* hdl/uad_pkg.sv */
// Constants, field layout and types of the address-detect receiver
package uad_pkg;
  localparam logic [7:0] OFS_RXSTAT  = 8'h00;
  localparam logic [7:0] OFS_RXDATA  = 8'h04;
  localparam logic [7:0] OFS_TXSTAT  = 8'h08;
  localparam logic [7:0] OFS_BAUDCTL = 8'h0c;
  localparam logic [7:0] OFS_DIVLO   = 8'h10;
  localparam logic [7:0] OFS_DIVHI   = 8'h14;
  localparam logic [7:0] OFS_IRQCTL  = 8'h18;

  localparam int RS_PORTEN = 7;
  localparam int RS_NINE   = 6;
  localparam int RS_CONT   = 4;
  localparam int RS_ADDR   = 3;
  localparam int TS_SYNC   = 4;
  localparam int TS_HIGH   = 2;
  localparam int TS_EMPTY  = 1;
  localparam int BC_IDLE   = 6;
  localparam int BC_WIDE   = 3;
  localparam int IC_GLOBAL = 7;
  localparam int IC_PERIPH = 6;
  localparam int IC_RXIE   = 5;
  localparam int IC_FLAG   = 0;

  localparam logic [7:0] RS_WMASK  = 8'hf8;
  localparam logic [7:0] TS_WMASK  = 8'hfd;
  localparam logic [7:0] BC_WMASK  = 8'h1b;
  localparam logic [7:0] IC_WMASK  = 8'he0;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [6:0] PRE_SLOW = 7'h40;
  localparam logic [6:0] PRE_MID  = 7'h10;
  localparam logic [6:0] PRE_FAST = 7'h04;

  localparam int RX_DEPTH   = 2;
  localparam int CHAR_WIDTH = 10;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} uad_rxst_t;
endpackage

/* hdl/uad_fifo.sv */
// Character buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module uad_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("uad_fifo: DEPTH must be 2 or more");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrIdx;
  logic [AW-1:0]    rdIdx;
  logic [AW:0]      count;
  logic             doPush;
  logic             doPop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
    bump = (idx == AW'(DEPTH - 1)) ? '0 : idx + 1'b1;
  endfunction

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdIdx];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrIdx] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrIdx <= '0;
      rdIdx <= '0;
      count <= '0;
    end else if (flush) begin
      wrIdx <= '0;
      rdIdx <= '0;
      count <= '0;
    end else begin
      if (doPush) wrIdx <= bump(wrIdx);
      if (doPop) rdIdx <= bump(rdIdx);
      if (doPush & ~doPop) count <= count + 1'b1;
      else if (doPop & ~doPush) count <= count - 1'b1;
    end
  end
endmodule // uad_fifo
`default_nettype wire

/* hdl/uad_baud.sv */
// Baud generator: one oversampling tick every divisor+1 clocks, low divisor byte only in narrow mode
`timescale 1ns/100ps
`default_nettype none
module uad_baud (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic        wide,
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] count;
  logic [15:0] reload;

  // Narrow mode ignores the high divisor byte
  assign reload = wide ? divisor : {8'h00, divisor[7:0]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (~enable) begin
      count <= reload;
      tick  <= 1'b0;
    end else if (count == 16'h0000) begin
      count <= reload;
      tick  <= 1'b1;
    end else begin
      count <= count - 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule // uad_baud
`default_nettype wire

/* verification/uad_line_node.sv */
// Remote transmitting node on the shared serial line
`timescale 1ns/100ps
`default_nettype none
module uad_line_node #(
  parameter int BIT_CLKS = 8
) (
  input  wire logic clk,
  output logic      rxd
);
  // Bus idles high through the line bias
  initial rxd = 1'b1;

  task automatic drive(input logic v, input int n);
    @(posedge clk);
    rxd <= v;
    repeat (n - 1) @(posedge clk);
  endtask

  // Nine bits LSB first; stop level chosen by the caller
  task automatic send(input logic [8:0] ch, input logic stopLvl);
    drive(1'b0, BIT_CLKS);
    for (int i = 0; i < 9; i++) begin
      drive(ch[i], BIT_CLKS);
    end
    drive(stopLvl, BIT_CLKS);
    drive(1'b1, BIT_CLKS);
  endtask

  // Low pulse shorter than half a bit: noise, not a start
  task automatic glitch();
    drive(1'b0, 2);
    drive(1'b1, BIT_CLKS);
  endtask
endmodule // uad_line_node
`default_nettype wire

/* verification/tb_uad_rx.sv */
// Register-level testbench of the address-detect receiver
`timescale 1ns/100ps
`default_nettype none
module tb_uad_rx;
  localparam logic [7:0] ASTAT = uad_pkg::OFS_RXSTAT;
  localparam logic [7:0] ADATA = uad_pkg::OFS_RXDATA;
  localparam logic [7:0] AIRQ  = uad_pkg::OFS_IRQCTL;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        rxIrq;
  logic [31:0] rd;
  logic        err;
  int          badCount;
  int          comparisons;

  uad_rx u_uad_rx (
    .clk     (clk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rxd     (rxd),
    .rxIrq   (rxIrq)
  );

  // Divisor 1 with both speed selects: 4 ticks of 2 clocks per bit
  uad_line_node #(.BIT_CLKS(8)) u_uad_line_node (
    .clk (clk),
    .rxd (rxd)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic giveVerdict();
    $display("mismatches %0d of %0d compares", badCount, comparisons);
    if (badCount == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is sampled high; no fixed latency assumed
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      badCount++;
      giveVerdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h0, exp});
  endtask

  task automatic irqChk(input logic exp);
    repeat (2) @(posedge clk);
    check({31'h0, rxIrq}, {31'h0, exp});
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    badCount++;
    giveVerdict();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    badCount = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdChk(ASTAT, 8'h00);
    rdChk(uad_pkg::OFS_TXSTAT, 8'h02);
    rdChk(ADATA, 8'h00);
    apb(1'b0, 8'h1c, 8'h00);
    check({31'h0, err}, 32'h1);
    // Set-up order: divisor, speed, interrupts, port with nine-bit, detect, receive
    apb(1'b1, uad_pkg::OFS_DIVLO, 8'h01);
    apb(1'b1, uad_pkg::OFS_DIVHI, 8'h00);
    apb(1'b1, uad_pkg::OFS_TXSTAT, 8'h04);
    apb(1'b1, uad_pkg::OFS_BAUDCTL, 8'h08);
    apb(1'b1, AIRQ, 8'he0);
    apb(1'b1, ASTAT, 8'hc0);
    apb(1'b1, ASTAT, 8'hc8);
    apb(1'b1, ASTAT, 8'hd8);
    // Data character ignored while detecting
    u_uad_line_node.send(9'h055, 1'b1);
    rdChk(AIRQ, 8'he0);
    irqChk(1'b0);
    u_uad_line_node.send(9'h1a5, 1'b1);
    irqChk(1'b1);
    rdChk(ASTAT, 8'hd9);
    rdChk(ADATA, 8'ha5);
    rdChk(AIRQ, 8'he0);
    // Noise pulse, then a real address
    u_uad_line_node.glitch();
    u_uad_line_node.send(9'h133, 1'b1);
    rdChk(ASTAT, 8'hd9);
    rdChk(ADATA, 8'h33);
    // Flag without interrupt enable
    apb(1'b1, AIRQ, 8'hc0);
    u_uad_line_node.send(9'h1c3, 1'b1);
    rdChk(AIRQ, 8'hc1);
    irqChk(1'b0);
    apb(1'b1, AIRQ, 8'he0);
    irqChk(1'b1);
    rdChk(ADATA, 8'hc3);
    // Addressed: detection off, all characters pass
    apb(1'b1, ASTAT, 8'hd0);
    u_uad_line_node.send(9'h042, 1'b1);
    rdChk(ASTAT, 8'hd0);
    rdChk(ADATA, 8'h42);
    u_uad_line_node.send(9'h07e, 1'b0);
    rdChk(ASTAT, 8'hd4);
    rdChk(ADATA, 8'h7e);
    u_uad_line_node.send(9'h081, 1'b1);
    rdChk(ASTAT, 8'hd0);
    rdChk(ADATA, 8'h81);
    // Third unread character overruns; the fourth never lands
    u_uad_line_node.send(9'h011, 1'b1);
    u_uad_line_node.send(9'h022, 1'b1);
    u_uad_line_node.send(9'h033, 1'b1);
    rdChk(ASTAT, 8'hd2);
    u_uad_line_node.send(9'h044, 1'b1);
    rdChk(ADATA, 8'h11);
    rdChk(ADATA, 8'h22);
    rdChk(AIRQ, 8'he0);
    apb(1'b1, ASTAT, 8'hc0);
    rdChk(ASTAT, 8'hc0);
    apb(1'b1, ASTAT, 8'hd0);
    u_uad_line_node.send(9'h1ff, 1'b1);
    rdChk(ASTAT, 8'hd1);
    rdChk(ADATA, 8'hff);
    // Eight-bit characters: ninth line bit stands as the stop bit
    apb(1'b1, ASTAT, 8'h90);
    u_uad_line_node.send(9'h1c5, 1'b1);
    rdChk(ASTAT, 8'h90);
    rdChk(ADATA, 8'hc5);
    giveVerdict();
  end
endmodule // tb_uad_rx
`default_nettype wire
